// ===== eag_pkg.sv
// constants, modes and register map of the effective address generator
// assumes a 16-bit core with byte addressed X and Y data spaces
// Behaviour
// [RULE_01] stack pointer marks first free word, grows up
// [RULE_02] call push clears program counter top bit
// [RULE_03] exception push places status byte on top
// [RULE_04] stack limit bit zero always reads zero
// [RULE_05] stack limit has no reset value
// [RULE_06] stack addresses compared with limit, trap past it
// [RULE_07] stack address below sfr bound traps
// [RULE_08] software avoids stack read right after limit write
// [RULE_09] boot ram reachable only from boot code
// [RULE_10] secure ram reachable only from secure code
// [RULE_11] file mode uses 13-bit direct address, implied W0
// [RULE_12] three-operand first operand is register direct
// [RULE_13] indirect, post, pre, indexed and literal offset modes
// [RULE_14] source and destination share one offset field
// [RULE_15] mac pointers eight, nine to X; ten, eleven Y
// [RULE_16] mac indexed only through pointers nine and eleven
// [RULE_17] mac post-modify by two, four or six
// [RULE_18] branch 16-bit signed, interrupt disable 14-bit literal
// [RULE_19] one circular buffer per space, any pointer
// [RULE_20] one direction, both bounds for power-of-two length
// [RULE_21] circular start and end are 16-bit registers
// [RULE_22] Y circular addresses keep bit zero clear
// [RULE_23] circular active when enabled and select not fifteen
// [RULE_24] bound checks catch addresses jumping past bounds
// [RULE_25] one stack trap pulse with the offending address
package eag_pkg;
    localparam logic [15:0] ADDR_SP = 16'h001E;
    localparam logic [15:0] ADDR_LIMIT = 16'h0020;
    localparam logic [15:0] ADDR_MODCTL = 16'h0046;
    localparam logic [15:0] ADDR_XSTART = 16'h0048;
    localparam logic [15:0] ADDR_XEND = 16'h004A;
    localparam logic [15:0] ADDR_YSTART = 16'h004C;
    localparam logic [15:0] ADDR_YEND = 16'h004E;
    localparam logic [15:0] ADDR_BOOTRAM = 16'h0750;
    localparam logic [15:0] ADDR_SECRAM = 16'h0752;
    localparam logic [15:0] ADDR_PDIS1 = 16'h0770;
    localparam logic [15:0] ADDR_PDIS2 = 16'h0772;
    localparam logic [15:0] ADDR_PDIS3 = 16'h0774;
    localparam logic [15:0] RST_PDIS = 16'h0000;
    localparam logic [15:0] RST_SP = 16'h0800;
    localparam logic [15:0] RST_MODCTL = 16'h00FF;
    localparam logic [15:0] RST_CIRC = 16'h0000;
    localparam logic [15:0] SFR_BOUND = 16'h0800;
    localparam logic [15:0] STACK_STEP = 16'h0002;
    localparam logic [3:0] SP_SEL = 4'hF;
    localparam logic [3:0] CIRC_OFF = 4'hF;
    localparam int MOD_XSEL_LSB = 0;
    localparam int MOD_YSEL_LSB = 4;
    localparam int MOD_YEN_BIT = 14;
    localparam int MOD_XEN_BIT = 15;
    localparam int PROT_EN_BIT = 0;
    localparam int FILE_ADDR_W = 13;
    localparam int IDIS_W = 14;
    typedef enum logic [3:0] {
        M_REG_DIRECT, M_FILE, M_IND, M_POST, M_PRE, M_INDEXED, M_LITOFF, M_MAC, M_BRANCH,
        M_IDIS
    } eag_mode_e;
    typedef enum logic [1:0] {PUSH_DATA, PUSH_PC_LO, PUSH_CALL_HI, PUSH_EXC_HI} eag_push_e;
endpackage

// ===== eag_top.sv
// effective address generator: stack, modes, circular buffers, ram guard
// assumes one decoder request per cycle and word-aligned pointers
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module eag_top #(
    parameter logic [15:0] BOOT_RAM_LO = 16'h0800,
    parameter logic [15:0] BOOT_RAM_HI = 16'h08FF,
    parameter logic [15:0] SEC_RAM_LO = 16'h0900,
    parameter logic [15:0] SEC_RAM_HI = 16'h09FF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic agu_req,
    input wire eag_pkg::eag_mode_e agu_mode,
    input wire logic [3:0] agu_ptr_sel,
    input wire logic [15:0] agu_ptr_val,
    input wire logic [15:0] agu_offset,
    input wire logic agu_space_y,
    input wire logic [1:0] mac_step,
    input wire logic mac_indexed,
    input wire logic stk_push,
    input wire logic stk_pop,
    input wire eag_pkg::eag_push_e push_kind,
    input wire logic [15:0] push_word,
    input wire logic [7:0] pc_high,
    input wire logic [7:0] status_low_byte,
    input wire logic exec_boot,
    input wire logic exec_secure,
    output logic [15:0] ea,
    output logic ea_valid,
    output logic ea_space_y,
    output logic [15:0] wb_value,
    output logic wb_en,
    output logic [3:0] wb_sel,
    output logic dwr_implied,
    output logic [15:0] push_data,
    output logic stack_trap,
    output logic prot_fault,
    output logic addr_err,
    output logic [15:0] sp
);
    import eag_pkg::*;

    logic [15:0] pdis1_ff, pdis2_ff, pdis3_ff, limit_ff, modctl_ff, bootram_ff, secram_ff;
    logic [15:0] xstart_ff, xend_ff, ystart_ff, yend_ff, sp_ff, rdata_ff;
    logic [15:0] ea_ff, wb_ff, push_ff;
    logic ea_valid_ff, ea_y_ff, wb_en_ff, dwr_ff, trap_ff, fault_ff, err_ff;
    logic [3:0] wb_sel_ff;
    logic [15:0] nxt_ea, nxt_wb, nxt_sp, nxt_push;
    logic nxt_valid, nxt_y, nxt_wb_en, nxt_dwr, nxt_trap, nxt_fault, nxt_err;
    logic [15:0] sum, sel_start, sel_end;
    logic circ_on, neg;

    // wraps an address that ran past a bound back into the buffer
    function automatic logic [15:0] circ_fix(input logic [15:0] a, input logic [15:0] st,
                                             input logic [15:0] en, input logic neg_dir);
        logic [15:0] len;
        logic pow2;
        len = en - st + 16'h0001;
        pow2 = ((len & (len - 16'h0001)) == 16'h0000);
        circ_fix = a;
        if ((!neg_dir || pow2) && a > en) begin // RULE_20 RULE_24
            circ_fix = a - len;
        end else if ((neg_dir || pow2) && a < st) begin // RULE_20 RULE_24
            circ_fix = a + len;
        end
    endfunction

    // register writes; peripheral disables, mode control, buffer bounds and ram guards
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pdis1_ff <= RST_PDIS;
            pdis2_ff <= RST_PDIS;
            pdis3_ff <= RST_PDIS;
            modctl_ff <= RST_MODCTL;
            xstart_ff <= RST_CIRC;
            xend_ff <= RST_CIRC;
            ystart_ff <= RST_CIRC;
            yend_ff <= RST_CIRC;
            bootram_ff <= RST_PDIS;
            secram_ff <= RST_PDIS;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_PDIS1: pdis1_ff <= reg_wdata;
                ADDR_PDIS2: pdis2_ff <= reg_wdata;
                ADDR_PDIS3: pdis3_ff <= reg_wdata;
                ADDR_MODCTL: modctl_ff <= reg_wdata;
                ADDR_XSTART: xstart_ff <= reg_wdata; // RULE_21
                ADDR_XEND: xend_ff <= reg_wdata; // RULE_21
                ADDR_YSTART: ystart_ff <= reg_wdata; // RULE_21
                ADDR_YEND: yend_ff <= reg_wdata; // RULE_21
                ADDR_BOOTRAM: bootram_ff <= reg_wdata;
                ADDR_SECRAM: secram_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    // stack limit keeps no reset value and stays word aligned
    always_ff @(posedge clk) begin
        if (reg_wr && reg_addr == ADDR_LIMIT) begin // RULE_05
            limit_ff <= {reg_wdata[15:1], 1'b0}; // RULE_04
        end
    end

    // read data, one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_ff <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_PDIS1: rdata_ff <= pdis1_ff;
                ADDR_PDIS2: rdata_ff <= pdis2_ff;
                ADDR_PDIS3: rdata_ff <= pdis3_ff;
                ADDR_SP: rdata_ff <= sp_ff;
                ADDR_LIMIT: rdata_ff <= {limit_ff[15:1], 1'b0}; // RULE_04
                ADDR_MODCTL: rdata_ff <= modctl_ff;
                ADDR_XSTART: rdata_ff <= xstart_ff;
                ADDR_XEND: rdata_ff <= xend_ff;
                ADDR_YSTART: rdata_ff <= ystart_ff;
                ADDR_YEND: rdata_ff <= yend_ff;
                ADDR_BOOTRAM: rdata_ff <= bootram_ff;
                ADDR_SECRAM: rdata_ff <= secram_ff;
                default: rdata_ff <= 16'h0000;
            endcase
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    // circular buffer applies only to the selected pointer of the space
    always_comb begin
        if (agu_space_y) begin
            circ_on = modctl_ff[MOD_YEN_BIT] && modctl_ff[MOD_YSEL_LSB +: 4] != CIRC_OFF && // RULE_23
                      modctl_ff[MOD_YSEL_LSB +: 4] == agu_ptr_sel; // RULE_19
            sel_start = ystart_ff;
            sel_end = yend_ff;
        end else begin
            circ_on = modctl_ff[MOD_XEN_BIT] && modctl_ff[MOD_XSEL_LSB +: 4] != CIRC_OFF && // RULE_23
                      modctl_ff[MOD_XSEL_LSB +: 4] == agu_ptr_sel; // RULE_19
            sel_start = xstart_ff;
            sel_end = xend_ff;
        end
    end

    // address formation for every request kind
    always_comb begin
        nxt_ea = ea_ff;
        nxt_wb = agu_ptr_val;
        nxt_sp = sp_ff;
        nxt_push = push_ff;
        nxt_valid = 1'b0;
        nxt_y = 1'b0;
        nxt_wb_en = 1'b0;
        nxt_dwr = 1'b0;
        nxt_trap = 1'b0;
        nxt_fault = 1'b0;
        nxt_err = 1'b0;
        sum = agu_ptr_val + agu_offset; // RULE_14
        neg = agu_offset[15];
        if (reg_wr && reg_addr == ADDR_SP) begin
            nxt_sp = {reg_wdata[15:1], 1'b0};
        end
        if (stk_push) begin
            nxt_ea = sp_ff; // RULE_01
            nxt_sp = sp_ff + STACK_STEP; // RULE_01
            nxt_valid = 1'b1;
            nxt_trap = sp_ff > limit_ff || sp_ff < SFR_BOUND; // RULE_06 RULE_07 RULE_25
            case (push_kind)
                PUSH_CALL_HI: nxt_push = {8'h00, 1'b0, pc_high[6:0]}; // RULE_02
                PUSH_EXC_HI: nxt_push = {status_low_byte, pc_high}; // RULE_03
                default: nxt_push = push_word;
            endcase
        end else if (stk_pop) begin
            nxt_ea = sp_ff - STACK_STEP; // RULE_01
            nxt_sp = sp_ff - STACK_STEP; // RULE_01
            nxt_valid = 1'b1;
            nxt_trap = nxt_ea < SFR_BOUND || nxt_ea > limit_ff; // RULE_06 RULE_07 RULE_25
        end else if (agu_req) begin
            nxt_valid = 1'b1;
            nxt_y = agu_space_y;
            case (agu_mode)
                M_REG_DIRECT: begin
                    nxt_valid = 1'b0; // RULE_12
                end
                M_FILE: begin
                    nxt_ea = {3'b000, agu_offset[FILE_ADDR_W-1:0]}; // RULE_11
                    nxt_dwr = 1'b1; // RULE_11
                    nxt_y = 1'b0;
                end
                M_IND: nxt_ea = agu_ptr_val; // RULE_13
                M_POST: begin
                    nxt_ea = agu_ptr_val; // RULE_13
                    nxt_wb = circ_on ? circ_fix(sum, sel_start, sel_end, neg) : sum; // RULE_24
                    nxt_wb_en = 1'b1;
                end
                M_PRE: begin
                    nxt_ea = circ_on ? circ_fix(sum, sel_start, sel_end, neg) : sum; // RULE_13
                    nxt_wb = nxt_ea;
                    nxt_wb_en = 1'b1;
                end
                M_INDEXED, M_LITOFF: begin
                    nxt_ea = circ_on ? circ_fix(sum, sel_start, sel_end, neg) : sum; // RULE_13
                end
                M_MAC: begin
                    nxt_y = agu_ptr_sel[1]; // RULE_15
                    nxt_err = agu_ptr_sel[3:2] != 2'b10 ||
                              (mac_indexed && !agu_ptr_sel[0]); // RULE_15 RULE_16
                    nxt_ea = mac_indexed ? sum : agu_ptr_val; // RULE_16
                    // step codes one, two, three add two, four, six bytes
                    nxt_wb = agu_ptr_val + {13'h0000, mac_step, 1'b0}; // RULE_17
                    nxt_wb_en = !mac_indexed && mac_step != 2'b00; // RULE_17
                end
                M_BRANCH: begin
                    nxt_ea = sum; // RULE_18
                    nxt_y = 1'b0;
                end
                M_IDIS: begin
                    nxt_ea = {2'b00, agu_offset[IDIS_W-1:0]}; // RULE_18
                    nxt_y = 1'b0;
                end
                default: nxt_valid = 1'b0;
            endcase
            if (nxt_y) begin
                nxt_ea[0] = 1'b0; // RULE_22
                nxt_wb[0] = 1'b0; // RULE_22
            end
            if (agu_ptr_sel == SP_SEL && agu_mode != M_FILE && nxt_valid) begin
                nxt_trap = nxt_ea > limit_ff || nxt_ea < SFR_BOUND; // RULE_06 RULE_07
            end
        end
        if (nxt_valid && bootram_ff[PROT_EN_BIT] && !exec_boot &&
            nxt_ea >= BOOT_RAM_LO && nxt_ea <= BOOT_RAM_HI) begin
            nxt_fault = 1'b1; // RULE_09
        end
        if (nxt_valid && secram_ff[PROT_EN_BIT] && !exec_secure &&
            nxt_ea >= SEC_RAM_LO && nxt_ea <= SEC_RAM_HI) begin
            nxt_fault = 1'b1; // RULE_10
        end
        if (nxt_fault || nxt_err) begin
            nxt_valid = 1'b0;
            nxt_wb_en = 1'b0;
        end
    end

    // stack pointer state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sp_ff <= RST_SP;
        end else begin
            sp_ff <= nxt_sp; // RULE_01
        end
    end

    // registered answer toward the data buses and exception logic
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ea_ff <= 16'h0000;
            wb_ff <= 16'h0000;
            push_ff <= 16'h0000;
            wb_sel_ff <= 4'h0;
            ea_valid_ff <= 1'b0;
            ea_y_ff <= 1'b0;
            wb_en_ff <= 1'b0;
            dwr_ff <= 1'b0;
            trap_ff <= 1'b0;
            fault_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            ea_ff <= nxt_ea;
            wb_ff <= nxt_wb;
            push_ff <= nxt_push;
            wb_sel_ff <= agu_ptr_sel;
            ea_valid_ff <= nxt_valid;
            ea_y_ff <= nxt_y;
            wb_en_ff <= nxt_wb_en;
            dwr_ff <= nxt_dwr;
            trap_ff <= nxt_trap; // RULE_25
            fault_ff <= nxt_fault;
            err_ff <= nxt_err;
        end
    end

    assign reg_rdata = rdata_ff;
    assign ea = ea_ff;
    assign ea_valid = ea_valid_ff;
    assign ea_space_y = ea_y_ff;
    assign wb_value = wb_ff;
    assign wb_en = wb_en_ff;
    assign wb_sel = wb_sel_ff;
    assign dwr_implied = dwr_ff;
    assign push_data = push_ff;
    assign stack_trap = trap_ff;
    assign prot_fault = fault_ff;
    assign addr_err = err_ff;
    assign sp = sp_ff;

    // checks on stack, modes and guard
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_LIMIT_LSB: assert property (reg_rd && reg_addr == ADDR_LIMIT |=> !reg_rdata[0]) // RULE_04
        else $error("stack limit bit zero read as one");
    AST_PUSH_STEP: assert property (stk_push && !(reg_wr && reg_addr == ADDR_SP)
        |=> sp == $past(sp) + STACK_STEP && ea == $past(sp)) // RULE_01
        else $error("push did not post-increment");
    AST_POP_STEP: assert property (stk_pop && !stk_push |=> ea == sp && ea == $past(sp) - STACK_STEP) // RULE_01
        else $error("pop did not pre-decrement");
    AST_CALL_MSB: assert property (stk_push && push_kind == PUSH_CALL_HI
        |=> push_data[15:7] == 9'h000) // RULE_02
        else $error("call push kept top bit");
    AST_EXC_CAT: assert property (stk_push && push_kind == PUSH_EXC_HI
        |=> push_data[15:8] == $past(status_low_byte)) // RULE_03
        else $error("exception push lost status byte");
    AST_LIMIT_EQ: assert property (stk_push && sp == limit_ff && sp >= SFR_BOUND |=> !stack_trap) // RULE_06
        else $error("push at limit trapped");
    AST_LIMIT_OVER: assert property (stk_push && !stk_pop && sp >= SFR_BOUND
        && sp == limit_ff + STACK_STEP |=> stack_trap) // RULE_06
        else $error("push past limit missed trap");
    AST_UNDER: assert property (stk_pop && !stk_push && sp < SFR_BOUND + STACK_STEP |=> stack_trap) // RULE_07
        else $error("underflow missed trap");
    AST_TRAP_CAUSE: assert property (stack_trap |-> $past(stk_push || stk_pop || agu_req)) // RULE_25
        else $error("trap without stack access");
    AST_FILE_13: assert property (agu_req && !stk_push && !stk_pop && agu_mode == M_FILE
        |=> ea[15:13] == 3'b000 && dwr_implied) // RULE_11
        else $error("file address exceeds near space");
    AST_MAC_Y: assert property (agu_req && !stk_push && !stk_pop && agu_mode == M_MAC
        && agu_ptr_sel[3:1] == 3'b101 |=> ea_space_y && !ea[0]) // RULE_15
        else $error("mac Y pointer left Y space");
    AST_MAC_IDX: assert property (agu_req && !stk_push && !stk_pop && agu_mode == M_MAC
        && mac_indexed && agu_ptr_sel == 4'h8 |=> addr_err && !ea_valid) // RULE_16
        else $error("mac indexed allowed on wrong pointer");
    AST_BOOT_GUARD: assert property (ea_valid |-> !(bootram_ff[PROT_EN_BIT] && !$past(exec_boot)
        && ea >= BOOT_RAM_LO && ea <= BOOT_RAM_HI)) // RULE_09
        else $error("boot ram reached from other code");

    COV_PUSH_TRAP: cover property (stk_push ##1 stack_trap);
    COV_CIRC_WRAP: cover property (agu_req && agu_mode == M_POST && circ_on && nxt_wb != sum);
    COV_MAC_POST: cover property (agu_req && agu_mode == M_MAC && mac_step == 2'b11 ##1 wb_en);
    COV_FAULT: cover property (prot_fault);
endmodule // eag_top

// ===== eag_mem_model.sv
// partner model: data memory that takes the words the generator pushes
// assumes a push lands at ea in the cycle after the push strobe is taken
`timescale 1ns/1ps
module eag_mem_model (
    input wire logic clk,
    input wire logic stk_push,
    input wire logic [15:0] ea,
    input wire logic ea_valid,
    input wire logic [15:0] push_data,
    input wire logic [15:0] peek_addr,
    output logic [15:0] peek_data
);
    logic [15:0] mem [0:2047];
    logic push_pend_ff;
    // remember that the request just taken was a push
    always_ff @(posedge clk) begin
        push_pend_ff <= stk_push;
    end
    // store the pushed word at the word address the generator produced
    always_ff @(posedge clk) begin
        if (push_pend_ff && ea_valid) begin
            mem[ea[11:1]] <= push_data;
        end
    end
    // word read port for the bench
    assign peek_data = mem[peek_addr[11:1]];
endmodule // eag_mem_model

// ===== effective_address_generator_test.sv
// self-checking bench for the effective address generator
// assumes eag_pkg, eag_top and eag_mem_model are compiled first
`timescale 1ns/1ps
module effective_address_generator_test;
    import eag_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, agu_req = 1'b0;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, agu_ptr_val = 16'h0000;
    logic [15:0] agu_offset = 16'h0000, push_word = 16'h0000, peek_addr = 16'h0000;
    logic [3:0] agu_ptr_sel = 4'h0;
    logic [1:0] mac_step = 2'h0;
    logic [7:0] pc_high = 8'h00, status_low_byte = 8'h00;
    logic agu_space_y = 1'b0, mac_indexed = 1'b0, stk_push = 1'b0, stk_pop = 1'b0;
    logic exec_boot = 1'b0, exec_secure = 1'b0;
    eag_mode_e agu_mode = M_IND;
    eag_push_e push_kind = PUSH_DATA;
    logic [15:0] reg_rdata, ea, wb_value, push_data, sp, peek_data;
    logic [3:0] wb_sel;
    logic ea_valid, ea_space_y, wb_en, dwr_implied, stack_trap, prot_fault, addr_err;
    int n_mismatch = 0;
    int checks_done = 0;

    eag_top eag_top_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .agu_req(agu_req),
        .agu_mode(agu_mode), .agu_ptr_sel(agu_ptr_sel), .agu_ptr_val(agu_ptr_val),
        .agu_offset(agu_offset), .agu_space_y(agu_space_y), .mac_step(mac_step),
        .mac_indexed(mac_indexed), .stk_push(stk_push), .stk_pop(stk_pop),
        .push_kind(push_kind), .push_word(push_word), .pc_high(pc_high),
        .status_low_byte(status_low_byte), .exec_boot(exec_boot), .exec_secure(exec_secure),
        .ea(ea), .ea_valid(ea_valid), .ea_space_y(ea_space_y), .wb_value(wb_value),
        .wb_en(wb_en), .wb_sel(wb_sel), .dwr_implied(dwr_implied), .push_data(push_data),
        .stack_trap(stack_trap), .prot_fault(prot_fault), .addr_err(addr_err), .sp(sp));
    eag_mem_model eag_mem_model_inst (.clk(clk), .stk_push(stk_push), .ea(ea),
        .ea_valid(ea_valid), .push_data(push_data), .peek_addr(peek_addr),
        .peek_data(peek_data));

    // 100 MHz clock
    always #5 clk = ~clk;

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle register write
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // one-cycle register read, data taken in the following cycle
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // one address request, outputs looked at one cycle later
    task automatic agu(input eag_mode_e m, input logic [3:0] s, input logic [15:0] v,
                       input logic [15:0] o, input logic y, input logic [1:0] st,
                       input logic ix);
        @(posedge clk);
        agu_req <= 1'b1;
        agu_mode <= m;
        agu_ptr_sel <= s;
        agu_ptr_val <= v;
        agu_offset <= o;
        agu_space_y <= y;
        mac_step <= st;
        mac_indexed <= ix;
        @(posedge clk);
        agu_req <= 1'b0;
        #1;
    endtask
    // one push or pop
    task automatic stk(input logic push, input eag_push_e k, input logic [15:0] w,
                       input logic [7:0] ph, input logic [7:0] sl);
        @(posedge clk);
        stk_push <= push;
        stk_pop <= !push;
        push_kind <= k;
        push_word <= w;
        pc_high <= ph;
        status_low_byte <= sl;
        @(posedge clk);
        stk_push <= 1'b0;
        stk_pop <= 1'b0;
        #1;
    endtask
    // execution segment levels
    task automatic set_exec(input logic b, input logic s);
        @(posedge clk);
        exec_boot <= b;
        exec_secure <= s;
    endtask

    // reset values, peripheral disable registers, unmapped place
    task automatic t_regs();
        chk(sp, RST_SP);
        rd_chk(ADDR_MODCTL, RST_MODCTL);
        for (int i = 0; i < 3; i++) begin
            rd_chk(ADDR_PDIS1 + 16'(2 * i), RST_PDIS);
            wr_reg(ADDR_PDIS1 + 16'(2 * i), 16'hA5C3 ^ 16'(i));
            rd_chk(ADDR_PDIS1 + 16'(2 * i), 16'hA5C3 ^ 16'(i));
        end
        wr_reg(16'h0100, 16'hFFFF);
        rd_chk(16'h0100, 16'h0000);
    endtask
    // pushes up to and past the limit, pops below the sfr bound
    task automatic t_stack();
        wr_reg(ADDR_LIMIT, 16'h0805);
        rd_chk(ADDR_LIMIT, 16'h0804);
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            stk(1'b1, PUSH_DATA, 16'h1000, 8'h00, 8'h00);
            chk(ea, 16'h0800 + 16'(2 * i));
            chk(sp, 16'h0802 + 16'(2 * i));
            chk({15'h0, stack_trap}, {15'h0, i == 3});
        end
        @(posedge clk);
        #1;
        chk({15'h0, stack_trap}, 16'h0000);
        wr_reg(ADDR_SP, 16'h0802);
        stk(1'b0, PUSH_DATA, 16'h0000, 8'h00, 8'h00);
        chk({ea[15:1], stack_trap}, {15'h0400, 1'b0});
        stk(1'b0, PUSH_DATA, 16'h0000, 8'h00, 8'h00);
        chk({ea[15:1], stack_trap}, {15'h03FF, 1'b1});
    endtask
    // call and exception pushes of the program counter
    task automatic t_pcpush();
        wr_reg(ADDR_SP, 16'h0800);
        stk(1'b1, PUSH_PC_LO, 16'h1234, 8'h00, 8'h00);
        stk(1'b1, PUSH_CALL_HI, 16'h0000, 8'hFF, 8'hA5);
        chk(push_data, 16'h007F);
        @(posedge clk);
        #1;
        peek_addr = 16'h0800;
        #1;
        chk(peek_data, 16'h1234);
        peek_addr = 16'h0802;
        #1;
        chk(peek_data, 16'h007F);
        wr_reg(ADDR_SP, 16'h0800);
        stk(1'b1, PUSH_PC_LO, 16'h5678, 8'h00, 8'h00);
        stk(1'b1, PUSH_EXC_HI, 16'h0000, 8'h3C, 8'hA5);
        chk(push_data, 16'hA53C);
    endtask
    // indirect family, register direct, file, branch, interrupt disable
    task automatic t_modes();
        eag_mode_e ms [5] = '{M_IND, M_POST, M_PRE, M_INDEXED, M_LITOFF};
        for (int i = 0; i < 5; i++) begin
            agu(ms[i], 4'h3, 16'h1200, 16'hFFFC, 1'b0, 2'h0, 1'b0);
            chk(ea, (i < 2) ? 16'h1200 : 16'h11FC);
            chk({ea_valid, 14'h0, wb_en}, {1'b1, 14'h0, i == 1 || i == 2});
            if (i == 1 || i == 2) chk({wb_sel, wb_value[11:0]}, 16'h31FC);
        end
        agu(M_REG_DIRECT, 4'h3, 16'h1200, 16'h0000, 1'b0, 2'h0, 1'b0);
        chk({15'h0, ea_valid}, 16'h0000);
        agu(M_FILE, 4'h5, 16'h0000, 16'hFFFF, 1'b0, 2'h0, 1'b0);
        chk({ea[14:0], dwr_implied}, {15'h1FFF, 1'b1});
        agu(M_BRANCH, 4'h0, 16'h0200, 16'hFFF0, 1'b0, 2'h0, 1'b0);
        chk(ea, 16'h01F0);
        agu(M_IDIS, 4'h0, 16'h0000, 16'hFFFF, 1'b0, 2'h0, 1'b0);
        chk(ea, 16'h3FFF);
    endtask
    // dual-operand pointers, steps, indexed and a refused pointer
    task automatic t_mac();
        logic [3:0] sels [3] = '{4'h8, 4'hA, 4'hB};
        for (int i = 0; i < 3; i++) begin
            agu(M_MAC, sels[i], 16'h0400, 16'h0000, i == 0, 2'(i + 1), 1'b0);
            chk(wb_value, 16'h0402 + 16'(2 * i));
            chk({ea[15:1], ea_space_y}, {15'h0200, i > 0});
        end
        agu(M_MAC, 4'h9, 16'h0400, 16'h0010, 1'b0, 2'h0, 1'b1);
        chk({ea[15:1], wb_en}, {15'h0208, 1'b0});
        agu(M_MAC, 4'h8, 16'h0400, 16'h0010, 1'b0, 2'h0, 1'b1);
        chk({14'h0, ea_valid, addr_err}, 16'h0001);
        agu(M_MAC, 4'h7, 16'h0400, 16'h0000, 1'b0, 2'h1, 1'b0);
        chk({14'h0, ea_valid, addr_err}, 16'h0001);
    endtask
    // circular buffers in X and Y
    task automatic t_circ();
        wr_reg(ADDR_XSTART, 16'h1000);
        wr_reg(ADDR_XEND, 16'h100F);
        wr_reg(ADDR_YSTART, 16'h2000);
        wr_reg(ADDR_YEND, 16'h201F);
        rd_chk(ADDR_XEND, 16'h100F);
        wr_reg(ADDR_MODCTL, 16'h80F2);
        agu(M_POST, 4'h2, 16'h100E, 16'h0004, 1'b0, 2'h0, 1'b0);
        chk(wb_value, 16'h1002);
        agu(M_POST, 4'h2, 16'h1000, 16'hFFFE, 1'b0, 2'h0, 1'b0);
        chk(wb_value, 16'h100E);
        agu(M_POST, 4'h3, 16'h100E, 16'h0004, 1'b0, 2'h0, 1'b0);
        chk(wb_value, 16'h1012);
        wr_reg(ADDR_MODCTL, 16'hC0FF);
        agu(M_POST, 4'h2, 16'h100E, 16'h0004, 1'b0, 2'h0, 1'b0);
        chk(wb_value, 16'h1012);
        wr_reg(ADDR_MODCTL, 16'h4040);
        agu(M_POST, 4'h4, 16'h201E, 16'h0004, 1'b1, 2'h0, 1'b0);
        chk(wb_value, 16'h2002);
    endtask
    // guarded ram segments against the executing segment
    task automatic t_prot();
        wr_reg(ADDR_BOOTRAM, 16'h0001);
        wr_reg(ADDR_SECRAM, 16'h0001);
        agu(M_IND, 4'h3, 16'h0810, 16'h0000, 1'b0, 2'h0, 1'b0);
        chk({14'h0, ea_valid, prot_fault}, 16'h0001);
        set_exec(1'b1, 1'b0);
        agu(M_IND, 4'h3, 16'h0810, 16'h0000, 1'b0, 2'h0, 1'b0);
        chk({14'h0, ea_valid, prot_fault}, 16'h0002);
        agu(M_IND, 4'h3, 16'h0910, 16'h0000, 1'b0, 2'h0, 1'b0);
        chk({14'h0, ea_valid, prot_fault}, 16'h0001);
        set_exec(1'b0, 1'b1);
        agu(M_IND, 4'h3, 16'h0910, 16'h0000, 1'b0, 2'h0, 1'b0);
        chk({14'h0, ea_valid, prot_fault}, 16'h0002);
    endtask

    // counts, verdict and end of run
    task automatic report_and_stop();
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #200us;
        n_mismatch++;
        report_and_stop();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        #1;
        t_regs();
        t_stack();
        t_pcpush();
        t_modes();
        t_mac();
        t_circ();
        t_prot();
        report_and_stop();
    end
endmodule // effective_address_generator_test
